/* File: dv/dso_pin_reader.sv */
// controller model that reads the terminal and relay pins
// assumes both pins are levels on ref_clk
`timescale 1ns/1ps
`default_nettype none
module dso_pin_reader (
   input  wire logic       ref_clk,
   input  wire logic       term_pin,
   input  wire logic       relay_pin,
   output var  logic [1:0] seen
);
   // one sample a cycle, like a relay input card
   always_ff @(posedge ref_clk) begin
      seen <= {relay_pin, term_pin};
   end
endmodule // dso_pin_reader
`default_nettype wire

/* File: dv/dso_status_out_sva.sv */
// checker on the apb ports of the status block
// assumes one clock ref_clk and a synchronous low reset
`timescale 1ns/1ps
`default_nettype none
module dso_status_out_sva (
   input wire logic        ref_clk,
   input wire logic        nrst,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // answer is one cycle wide, after a full access cycle
   sequence s_pulse;
      pready ##1 !pready;
   endsequence
   property p_pulse; pready |-> s_pulse; endproperty
   a_pulse: assert property (p_pulse)
      else $error("pready longer than one cycle");
   property p_acc; pready |-> psel && penable && $past(penable); endproperty
   a_acc: assert property (p_acc)
      else $error("pready without two access cycles");
   property p_idle; !psel |-> !pready; endproperty
   a_idle: assert property (p_idle)
      else $error("pready while not selected");
   property p_err; pslverr |-> pready; endproperty
   a_err: assert property (p_err)
      else $error("pslverr without pready");
   // holes in the map are refused, read back as zero
   property p_unmap;
      pready && paddr inside {8'h34, 8'h38, 8'h3c} |-> pslverr;
   endproperty
   a_unmap: assert property (p_unmap)
      else $error("unmapped access not refused");
   property p_map;
      pready && paddr <= 8'h30 && paddr[1:0] == 2'h0 |-> !pslverr;
   endproperty
   a_map: assert property (p_map)
      else $error("mapped access refused");
   property p_zero; pslverr && !pwrite |-> prdata == 32'h0; endproperty
   a_zero: assert property (p_zero)
      else $error("refused read data not zero");
   // unused field bits of selection and flag words read zero
   property p_route;
      pready && !pwrite && paddr == 8'h18 |->
         prdata[31:14] == 18'h0 && prdata[7:6] == 2'h0;
   endproperty
   a_route: assert property (p_route)
      else $error("selection word has stray bits");
   property p_flags;
      pready && !pwrite && paddr == 8'h28 |-> prdata[31:7] == 25'h0;
   endproperty
   a_flags: assert property (p_flags)
      else $error("flag word has stray bits");
endmodule // dso_status_out_sva
`default_nettype wire

/* File: dv/tb.sv */
// bench: apb master, integer flag model and pin reader
// assumes a 250 MHz clock and a ten cycle hour
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.svh"
module tb;
   logic                 ref_clk, nrst, psel, penable, pwrite, err;
   logic                 pready, pslverr, out_terminal, alarm_relay, irq;
   logic [7:0]           paddr;
   logic [31:0]          pwdata, prdata, rd;
   logic [15:0]          out_freq;
   logic [2:0]           speed_sel, m;
   logic [1:0]           seen;
   dso_pkg::dso_motion_s motion;
   int                   n_mismatch, compares, f, s, k, j, tgt, thr;
   int                   cs, ov, rc, z, ef;
   int                   ms [3] = '{5000, 2000, 7000};
   int                   cb [7] = '{1, 2, 6, 11, 12, 21, 33};

   dso_status_out #(.CYC_PER_HOUR(64'd10)) DUT (
      .ref_clk(ref_clk), .nrst(nrst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .out_freq(out_freq),
      .motion(motion), .speed_sel(speed_sel), .out_terminal(out_terminal),
      .alarm_relay(alarm_relay), .irq(irq));
   dso_pin_reader u_rd (.ref_clk(ref_clk), .term_pin(out_terminal),
      .relay_pin(alarm_relay), .seen(seen));

   // free running clock
   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   task automatic chk(input string nm, input logic [31:0] e, g);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, e, g);
      end
   endtask

   task automatic conclude();
      $display("mismatches %0d compares %0d", n_mismatch, compares);
      if (n_mismatch == 0 && compares > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // one transfer; request held until pready is seen at an edge,
   // a slave that never answers is left to the hang guard
   task automatic apb(input logic w, input logic [7:0] a, input int d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin
         @(posedge ref_clk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask

   // route two codes, drive one point, advance the model, compare
   task automatic step();
      apb(1'b1, `DSO_ROUTE_OFS, cb[(k + 3) % 7] << 8 | cb[k % 7]);
      apb(1'b1, `DSO_LOGIC_OFS, (k % 3) << 16 | 32'h1501);
      out_freq <= 16'(f);
      motion <= m;
      speed_sel <= 3'(s);
      tgt = ms[s];
      z = int'(f < 500);
      cs = f >= tgt - 100 ? 1 : f < tgt - 200 ? 0 : cs;
      ov = thr == 0 ? 0 : f >= thr - 100 ? 1 : f < thr - 200 ? 0 : ov;
      rc = m[2] ? int'(f >= thr - 100 && f < thr + 200)
                : int'(f > thr - 200 && f <= thr + 100);
      ef = cs | ov << 1 | (thr != 0 ? rc : 0) << 2 | z << 5;
      ef |= (k % 3 == 0 ? cs & z : k % 3 == 1 ? cs | z : cs ^ z) << 6;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, `DSO_FLAGS_OFS, 0);
      chk("flags", ef, rd);
      chk("pins", {ef[(k + 3) % 7], ef[k % 7]}, seen);
   endtask

   initial begin
      nrst = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      out_freq = 16'h0;
      motion = '0;
      speed_sel = 3'h0;
      void'($urandom(43348));
      repeat (8) @(posedge ref_clk);
      nrst <= 1'b1;
      @(posedge ref_clk);
      apb(1'b0, `DSO_MAX_FREQ_OFS, 0);
      chk("max_freq", 32'h1770, rd);
      apb(1'b0, `DSO_ROUTE_OFS, 0);
      chk("route", 32'h3f3f, rd);
      apb(1'b0, 8'h38, 0);
      chk("slverr", 1, err);
      apb(1'b1, `DSO_MAX_FREQ_OFS, 10000);
      apb(1'b1, `DSO_ZERO_LVL_OFS, 500);
      for (j = 0; j < 3; j++)
         apb(1'b1, j == 0 ? `DSO_FREQ_CMD_OFS : 8'h40 + 8'(4 * j), ms[j]);
      // stopped drive: only power-on time passes the limit
      apb(1'b1, `DSO_WARN_TIME_OFS, 1);
      repeat (150) @(posedge ref_clk);
      apb(1'b0, `DSO_FLAGS_OFS, 0);
      chk("time", 32'h10, rd & 32'h18);
      apb(1'b1, `DSO_WARN_TIME_OFS, 0);
      // threshold enabled, then zero to disable it
      for (j = 0; j < 2; j++) begin
         thr = j == 0 ? 3000 : 0;
         apb(1'b1, `DSO_ACCEL_THR_OFS, thr);
         apb(1'b1, `DSO_DECEL_THR_OFS, thr);
         for (k = 0; k < 21; k++) begin
            f = k % 2 ? $urandom_range(7000) : 2750 + $urandom_range(500);
            m = $urandom_range(1) ? 3'b101 : 3'b011;
            s = $urandom_range(2);
            step();
         end
      end
      apb(1'b1, `DSO_WARN_TIME_OFS, 1);
      apb(1'b0, `DSO_FLAGS_OFS, 0);
      chk("time", 32'h18, rd & 32'h18);
      apb(1'b1, `DSO_WARN_TIME_OFS, 1000);
      apb(1'b0, `DSO_FLAGS_OFS, 0);
      chk("time_big", 32'h0, rd & 32'h18);
      // zero speed event: held off by the mask, then raised, then read away
      out_freq <= 16'd6000;
      repeat (3) @(posedge ref_clk);
      apb(1'b0, `DSO_STATUS_OFS, 0);
      out_freq <= 16'd0;
      repeat (4) @(posedge ref_clk);
      chk("irq_masked", 0, irq);
      apb(1'b1, `DSO_MASK_OFS, 32'h20);
      repeat (2) @(posedge ref_clk);
      chk("irq", 1, irq);
      apb(1'b0, `DSO_STATUS_OFS, 0);
      chk("status", 32'h20, rd & 32'h20);
      repeat (2) @(posedge ref_clk);
      chk("irq_clear", 0, irq);
      // logical flag is high here; naming itself as operand must give 0
      apb(1'b1, `DSO_LOGIC_OFS, 32'h12121);
      apb(1'b0, `DSO_FLAGS_OFS, 0);
      chk("self_operand", 32'h0, rd & 32'h40);
      conclude();
   end

   // hang guard, far beyond the expected run
   initial begin
      #100000;
      n_mismatch++;
      conclude();
   end
endmodule // tb

bind dso_status_out dso_status_out_sva u_sva (.ref_clk(ref_clk),
   .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

/* File: verilog/dso_defs.svh */
// constants for the drive status output block: register offsets,
// field positions, reset values, function codes and timing counts.
// assumes a 250 MHz clock and frequencies held in 0.01 Hz steps.
`ifndef DSO_DEFS_SVH
`define DSO_DEFS_SVH

// register byte offsets on the apb bus
`define DSO_FREQ_CMD_OFS    8'h00
`define DSO_MAX_FREQ_OFS    8'h04
`define DSO_ACCEL_THR_OFS   8'h08
`define DSO_DECEL_THR_OFS   8'h0c
`define DSO_ZERO_LVL_OFS    8'h10
`define DSO_WARN_TIME_OFS   8'h14
`define DSO_ROUTE_OFS       8'h18
`define DSO_LOGIC_OFS       8'h1c
`define DSO_STATUS_OFS      8'h20
`define DSO_MASK_OFS        8'h24
`define DSO_FLAGS_OFS       8'h28
`define DSO_RUN_HOURS_OFS   8'h2c
`define DSO_ON_HOURS_OFS    8'h30
`define DSO_MS_BASE_OFS     8'h40

// field positions
`define DSO_TERM_SEL_LSB    0
`define DSO_RELAY_SEL_LSB   8
`define DSO_OPA_LSB         0
`define DSO_OPB_LSB         8
`define DSO_OP_LSB          16

// output function codes (decimal numbers held in six bits)
`define DSO_CODE_SPD        6'd1
`define DSO_CODE_OVR        6'd2
`define DSO_CODE_RCH        6'd6
`define DSO_CODE_RUN        6'd11
`define DSO_CODE_PON        6'd12
`define DSO_CODE_ZRO        6'd21
`define DSO_CODE_LOG        6'd33
`define DSO_CODE_MAX        6'd60
`define DSO_CODE_NONE       6'd63

// hysteresis in percent of maximum frequency
`define DSO_PCT_ON          18'd1
`define DSO_PCT_OFF         18'd2
`define DSO_PCT_DIV         18'd100

// warning time scaling
`define DSO_WARN_BIG_MIN    16'd1000
`define DSO_WARN_BIG_MAX    16'd6553
`define DSO_WARN_UNIT_SMALL 24'd10
`define DSO_WARN_UNIT_BIG   24'd100

// timing: one hour at the clock rate
`define DSO_CLK_HZ          64'd250000000
`define DSO_SEC_PER_HOUR    64'd3600
`define DSO_CYC_PER_HOUR    (`DSO_CLK_HZ * `DSO_SEC_PER_HOUR)

// reset values
`define DSO_FREQ_CMD_RST    16'h0000
`define DSO_MAX_FREQ_RST    16'h1770
`define DSO_THR_RST         16'h0000
`define DSO_WARN_RST        16'h0000

`endif

/* File: verilog/dso_pkg.sv */
// types for the drive status output block.
// assumes dso_defs.svh supplies the numeric constants.
package dso_pkg;

   // logical output operator
   typedef enum logic [1:0] {
      DSO_OP_AND = 2'h0,
      DSO_OP_OR  = 2'h1,
      DSO_OP_XOR = 2'h2
   } dso_op_e;

   // the live status flags, one bit each
   typedef struct packed {
      logic log_comb;
      logic zero_speed;
      logic on_over;
      logic run_over;
      logic thr_reached;
      logic thr_over;
      logic const_speed;
   } dso_flags_s;

   // motion state of the output frequency
   typedef struct packed {
      logic accel;
      logic decel;
      logic running;
   } dso_motion_s;

endpackage

/* File: verilog/dso_status_out.sv */
// drive status output block: frequency arrival, time over, zero speed
// and logical flags, routed to an output terminal and an alarm relay.
// assumes out_freq, motion and speed_sel come from logic on ref_clk.
`timescale 1ns/1ps
`default_nettype none
`include "dso_defs.svh"

module dso_status_out #(
   parameter logic [63:0] CYC_PER_HOUR = `DSO_CYC_PER_HOUR
) (
   input  wire logic               ref_clk,
   input  wire logic               nrst,
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output var  logic [31:0]        prdata,
   output var  logic               pready,
   output var  logic               pslverr,
   input  wire logic [15:0]        out_freq,
   input  wire dso_pkg::dso_motion_s motion,
   input  wire logic [2:0]         speed_sel,
   output var  logic               out_terminal,
   output var  logic               alarm_relay,
   output var  logic               irq
);

   // percentage of the maximum frequency, widened against overflow
   function automatic logic [17:0] pct(input logic [15:0] f,
                                       input logic [17:0] n);
      logic [17:0] prod;
      prod = {2'b00, f} * n;
      pct = prod / `DSO_PCT_DIV;
   endfunction

   // a + p >= t, i.e. a at or above t minus p, without going negative
   function automatic logic at_least(input logic [15:0] a,
                                     input logic [15:0] t,
                                     input logic [17:0] p);
      at_least = ({2'b00, a} + p) >= {2'b00, t};
   endfunction

   // a <= t + p
   function automatic logic at_most(input logic [15:0] a,
                                    input logic [15:0] t,
                                    input logic [17:0] p);
      at_most = {2'b00, a} <= ({2'b00, t} + p);
   endfunction

   // pick one flag by function code; the logical flag is picked by its code like the others
   function automatic logic pick(input logic [5:0] code,
                                 input dso_pkg::dso_flags_s f);
      pick = 1'b0;
      case (code)
         `DSO_CODE_SPD: pick = f.const_speed;
         `DSO_CODE_OVR: pick = f.thr_over;
         `DSO_CODE_RCH: pick = f.thr_reached;
         `DSO_CODE_RUN: pick = f.run_over;
         `DSO_CODE_PON: pick = f.on_over;
         `DSO_CODE_ZRO: pick = f.zero_speed;
         `DSO_CODE_LOG: pick = f.log_comb;
         default:       pick = 1'b0;
      endcase
   endfunction

   // warning limit in hours
   function automatic logic [23:0] limit_hours(input logic [15:0] w);
      if ((w >= `DSO_WARN_BIG_MIN) && (w <= `DSO_WARN_BIG_MAX)) begin
         limit_hours = 24'({8'h00, w} * `DSO_WARN_UNIT_BIG);
      end else begin
         limit_hours = 24'({8'h00, w} * `DSO_WARN_UNIT_SMALL);
      end
   endfunction

   // configuration registers
   logic [15:0] freq_cmd;
   logic [15:0] max_freq;
   logic [15:0] accel_arrival_threshold;
   logic [15:0] decel_arrival_threshold;
   logic [15:0] zero_speed_level;
   logic [15:0] time_warning_setting;
   logic [5:0]  output_terminal_select;
   logic [5:0]  alarm_relay_select;
   logic [5:0]  logic_operand_a_select;
   logic [5:0]  logic_operand_b_select;
   logic [1:0]  logic_operator_select;
   logic [15:0] multispeed_settings [1:7];
   logic [6:0]  status;
   logic [6:0]  mask;
   logic [15:0] next_freq_cmd;
   logic [15:0] next_max_freq;
   logic [15:0] next_accel_thr;
   logic [15:0] next_decel_thr;
   logic [15:0] next_zero_lvl;
   logic [15:0] next_warn;
   logic [5:0]  next_term_sel;
   logic [5:0]  next_relay_sel;
   logic [5:0]  next_opa;
   logic [5:0]  next_opb;
   logic [1:0]  next_op;
   logic [15:0] next_ms [1:7];
   logic [6:0]  next_status;
   logic [6:0]  next_mask;
   logic [31:0] next_prdata;
   logic        next_pready;
   logic        next_pslverr;
   logic        next_irq;

   // flag state
   dso_pkg::dso_flags_s flags;
   dso_pkg::dso_flags_s next_flags;
   logic        next_out_terminal;
   logic        next_alarm_relay;

   // time counting state
   logic [63:0] run_cyc;
   logic [63:0] on_cyc;
   logic [23:0] run_hours;
   logic [23:0] on_hours;
   logic [63:0] next_run_cyc;
   logic [63:0] next_on_cyc;
   logic [23:0] next_run_hours;
   logic [23:0] next_on_hours;

   // derived terms
   logic [17:0] p_on;
   logic [17:0] p_off;
   logic [15:0] target;
   logic [15:0] ovr_thr;
   logic        acc_go;
   logic        wr_go;
   logic        rd_go;
   logic        op_a;
   logic        op_b;
   logic [6:0]  events;

   // handshake: pready rises in the second access cycle
   assign acc_go = psel & penable & pready;
   assign wr_go  = acc_go & pwrite;
   assign rd_go  = acc_go & ~pwrite;

   assign p_on  = pct(max_freq, `DSO_PCT_ON);
   assign p_off = pct(max_freq, `DSO_PCT_OFF);

   assign target = (speed_sel == 3'd0) ? freq_cmd
                                       : multispeed_settings[speed_sel];

   assign ovr_thr = motion.decel ? decel_arrival_threshold
                                 : accel_arrival_threshold;

   // operands exclude the logical flag and unassigned codes
   assign op_a = (logic_operand_a_select <= `DSO_CODE_MAX) &&
                 (logic_operand_a_select != `DSO_CODE_LOG) &&
                 pick(logic_operand_a_select, flags);
   assign op_b = (logic_operand_b_select <= `DSO_CODE_MAX) &&
                 (logic_operand_b_select != `DSO_CODE_LOG) &&
                 pick(logic_operand_b_select, flags);

   // rising edges of the live flags feed the sticky status
   assign events = next_flags & ~flags;

   // flag evaluation, every clock cycle
   always_comb begin
      next_flags = flags;
      if (at_least(out_freq, target, p_on)) begin
         next_flags.const_speed = 1'b1;
      end else if (!at_least(out_freq, target, p_off)
                   || out_freq == 16'h0000 && target != 16'h0000
                   && !at_least(out_freq, target, p_off)) begin
         next_flags.const_speed = 1'b0;
      end
      if (ovr_thr == 16'h0000) begin
         next_flags.thr_over = 1'b0;
      end else if (at_least(out_freq, ovr_thr, p_on)) begin
         next_flags.thr_over = 1'b1;
      end else if (!at_least(out_freq, ovr_thr, p_off)) begin
         next_flags.thr_over = 1'b0;
      end
      // reached only inside the band around the threshold
      if (motion.accel) begin
         if (accel_arrival_threshold == 16'h0000) begin
            next_flags.thr_reached = 1'b0;
         // on at minus 1%, off past plus 2%
         end else begin
            next_flags.thr_reached =
               at_least(out_freq, accel_arrival_threshold, p_on) &&
               !at_least(out_freq, accel_arrival_threshold
                         + 16'(p_off), 18'd0);
         end
      end else if (motion.decel) begin
         if (decel_arrival_threshold == 16'h0000) begin
            next_flags.thr_reached = 1'b0;
         // on at plus 1%, off below minus 2%
         end else begin
            next_flags.thr_reached =
               at_most(out_freq, decel_arrival_threshold, p_on) &&
               at_least(out_freq, decel_arrival_threshold, p_off) &&
               (out_freq != 16'(({2'b00, decel_arrival_threshold}
                                  - p_off)));
         end
      end else if (!at_least(out_freq, ovr_thr, p_off) ||
                   !at_most(out_freq, ovr_thr, p_off) ||
                   ovr_thr == 16'h0000) begin
         // steady speed holds the flag only while still in the band
         next_flags.thr_reached = 1'b0;
      end
      next_flags.run_over = (time_warning_setting != 16'h0000) &&
                            (run_hours > limit_hours(time_warning_setting));
      next_flags.on_over  = (time_warning_setting != 16'h0000) &&
                            (on_hours > limit_hours(time_warning_setting));
      next_flags.zero_speed = out_freq < zero_speed_level;
      case (logic_operator_select)
         dso_pkg::DSO_OP_AND: next_flags.log_comb = op_a & op_b;
         dso_pkg::DSO_OP_OR:  next_flags.log_comb = op_a | op_b;
         dso_pkg::DSO_OP_XOR: next_flags.log_comb = op_a ^ op_b;
         default:             next_flags.log_comb = 1'b0;
      endcase
      next_out_terminal = pick(output_terminal_select, flags);
      next_alarm_relay  = pick(alarm_relay_select, flags);
   end

   // flag registers; pins lag the flags by one cycle
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         flags        <= '0;
         out_terminal <= 1'b0;
         alarm_relay  <= 1'b0;
      end else begin
         flags        <= next_flags;
         out_terminal <= next_out_terminal;
         alarm_relay  <= next_alarm_relay;
      end
   end

   // hour counters; hours saturate rather than wrap back to zero
   always_comb begin
      next_run_cyc   = run_cyc;
      next_on_cyc    = on_cyc;
      next_run_hours = run_hours;
      next_on_hours  = on_hours;
      if (on_cyc >= CYC_PER_HOUR - 64'd1) begin
         next_on_cyc = 64'd0;
         if (on_hours != 24'hffffff) begin
            next_on_hours = on_hours + 24'd1;
         end
      end else begin
         next_on_cyc = on_cyc + 64'd1;
      end
      if (motion.running) begin
         if (run_cyc >= CYC_PER_HOUR - 64'd1) begin
            next_run_cyc = 64'd0;
            if (run_hours != 24'hffffff) begin
               next_run_hours = run_hours + 24'd1;
            end
         end else begin
            next_run_cyc = run_cyc + 64'd1;
         end
      end
   end

   // hour counter registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         run_cyc   <= 64'd0;
         on_cyc    <= 64'd0;
         run_hours <= 24'd0;
         on_hours  <= 24'd0;
      end else begin
         run_cyc   <= next_run_cyc;
         on_cyc    <= next_on_cyc;
         run_hours <= next_run_hours;
         on_hours  <= next_on_hours;
      end
   end

   // apb decode and register updates; a new event beats a read clear
   always_comb begin
      next_freq_cmd  = freq_cmd;
      next_max_freq  = max_freq;
      next_accel_thr = accel_arrival_threshold;
      next_decel_thr = decel_arrival_threshold;
      next_zero_lvl  = zero_speed_level;
      next_warn      = time_warning_setting;
      next_term_sel  = output_terminal_select;
      next_relay_sel = alarm_relay_select;
      next_opa       = logic_operand_a_select;
      next_opb       = logic_operand_b_select;
      next_op        = logic_operator_select;
      next_ms        = multispeed_settings;
      next_mask      = mask;
      next_status    = status;
      next_prdata    = prdata;
      next_pslverr   = 1'b0;
      next_pready    = psel & penable & ~pready;
      if (rd_go && paddr == `DSO_STATUS_OFS) begin
         next_status = 7'h00;
      end
      next_status = next_status | events;
      if (psel && penable && !pready) begin
         next_prdata = 32'h00000000;
         if (paddr == `DSO_FREQ_CMD_OFS) begin
            next_prdata = {16'h0000, freq_cmd};
         end else if (paddr == `DSO_MAX_FREQ_OFS) begin
            next_prdata = {16'h0000, max_freq};
         end else if (paddr == `DSO_ACCEL_THR_OFS) begin
            next_prdata = {16'h0000, accel_arrival_threshold};
         end else if (paddr == `DSO_DECEL_THR_OFS) begin
            next_prdata = {16'h0000, decel_arrival_threshold};
         end else if (paddr == `DSO_ZERO_LVL_OFS) begin
            next_prdata = {16'h0000, zero_speed_level};
         end else if (paddr == `DSO_WARN_TIME_OFS) begin
            next_prdata = {16'h0000, time_warning_setting};
         end else if (paddr == `DSO_ROUTE_OFS) begin
            next_prdata = {18'h00000, alarm_relay_select,
                           2'b00, output_terminal_select};
         end else if (paddr == `DSO_LOGIC_OFS) begin
            next_prdata = {14'h0000, logic_operator_select, 2'b00,
                           logic_operand_b_select, 2'b00,
                           logic_operand_a_select};
         end else if (paddr == `DSO_STATUS_OFS) begin
            next_prdata = {25'h0000000, status};
         end else if (paddr == `DSO_MASK_OFS) begin
            next_prdata = {25'h0000000, mask};
         end else if (paddr == `DSO_FLAGS_OFS) begin
            next_prdata = {25'h0000000, flags};
         end else if (paddr == `DSO_RUN_HOURS_OFS) begin
            next_prdata = {8'h00, run_hours};
         end else if (paddr == `DSO_ON_HOURS_OFS) begin
            next_prdata = {8'h00, on_hours};
         end else if (paddr[7:5] == 3'b010 && paddr[4:2] != 3'd0 &&
                      paddr[1:0] == 2'b00) begin
            next_prdata = {16'h0000, multispeed_settings[paddr[4:2]]};
         end else begin
            next_pslverr = 1'b1;
         end
      end
      if (wr_go) begin
         if (paddr == `DSO_FREQ_CMD_OFS) begin
            next_freq_cmd = pwdata[15:0];
         end else if (paddr == `DSO_MAX_FREQ_OFS) begin
            next_max_freq = pwdata[15:0];
         end else if (paddr == `DSO_ACCEL_THR_OFS) begin
            next_accel_thr = pwdata[15:0];
         end else if (paddr == `DSO_DECEL_THR_OFS) begin
            next_decel_thr = pwdata[15:0];
         end else if (paddr == `DSO_ZERO_LVL_OFS) begin
            next_zero_lvl = pwdata[15:0];
         end else if (paddr == `DSO_WARN_TIME_OFS) begin
            next_warn = pwdata[15:0];
         end else if (paddr == `DSO_ROUTE_OFS) begin
            next_term_sel  = pwdata[`DSO_TERM_SEL_LSB +: 6];
            next_relay_sel = pwdata[`DSO_RELAY_SEL_LSB +: 6];
         end else if (paddr == `DSO_LOGIC_OFS) begin
            next_opa = pwdata[`DSO_OPA_LSB +: 6];
            next_opb = pwdata[`DSO_OPB_LSB +: 6];
            next_op  = pwdata[`DSO_OP_LSB +: 2];
         end else if (paddr == `DSO_MASK_OFS) begin
            next_mask = pwdata[6:0];
         end else if (paddr[7:5] == 3'b010 && paddr[4:2] != 3'd0 &&
                      paddr[1:0] == 2'b00) begin
            next_ms[paddr[4:2]] = pwdata[15:0];
         end
      end
      next_irq = |(next_status & next_mask);
   end

   // register file and bus answer registers
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         freq_cmd                <= `DSO_FREQ_CMD_RST;
         max_freq                <= `DSO_MAX_FREQ_RST;
         accel_arrival_threshold <= `DSO_THR_RST;
         decel_arrival_threshold <= `DSO_THR_RST;
         zero_speed_level        <= `DSO_THR_RST;
         time_warning_setting    <= `DSO_WARN_RST;
         output_terminal_select  <= `DSO_CODE_NONE;
         alarm_relay_select      <= `DSO_CODE_NONE;
         logic_operand_a_select  <= `DSO_CODE_NONE;
         logic_operand_b_select  <= `DSO_CODE_NONE;
         logic_operator_select   <= 2'h0;
         for (int i = 1; i <= 7; i++) begin
            multispeed_settings[i] <= `DSO_FREQ_CMD_RST;
         end
         status  <= 7'h00;
         mask    <= 7'h00;
         prdata  <= 32'h00000000;
         pready  <= 1'b0;
         pslverr <= 1'b0;
         irq     <= 1'b0;
      end else begin
         freq_cmd                <= next_freq_cmd;
         max_freq                <= next_max_freq;
         accel_arrival_threshold <= next_accel_thr;
         decel_arrival_threshold <= next_decel_thr;
         zero_speed_level        <= next_zero_lvl;
         time_warning_setting    <= next_warn;
         output_terminal_select  <= next_term_sel;
         alarm_relay_select      <= next_relay_sel;
         logic_operand_a_select  <= next_opa;
         logic_operand_b_select  <= next_opb;
         logic_operator_select   <= next_op;
         multispeed_settings     <= next_ms;
         status  <= next_status;
         mask    <= next_mask;
         prdata  <= next_prdata;
         pready  <= next_pready;
         pslverr <= next_pslverr;
         irq     <= next_irq;
      end
   end

endmodule // dso_status_out

`default_nettype wire
